//--- branch_timing_defs.svh
// Timing and field constants for the branch condition and step timing block
`ifndef BRANCH_TIMING_DEFS_SVH
`define BRANCH_TIMING_DEFS_SVH

// ==========================================================
// Clock and time base (all times held in microseconds)
// ==========================================================
`define CLK_MHZ 7'h64
`define TIME_W 16

// ==========================================================
// Location reference times
// ==========================================================
`define REF_REG_US 16'h0384
`define LOAD_BUF_US 16'h0384
`define LOAD_DRUM_US 16'h0C1C
`define FIELD_POS_US 16'h0015
`define CHAR_US 16'h002A
`define FIELD_SHORT_CHARS 7'h0C
`define STORE_DRUM_US 16'h0C1C
`define BTB_FILL_GSB_US 16'h1518
`define BTB_FILL_DRUM_US 16'h1E14
`define BTB_TO_DRUM_US 16'h0C80
`define BTB_WHOLE_US 16'h13EC
`define SHIFT_US 16'h002A

// ==========================================================
// Process, floor, constant and fetch times
// ==========================================================
`define ADD_NUM_US 16'h04B0
`define ADD_CHECK_US 16'h09C4
`define ADD_ALPHA_US 16'h02BC
`define PROC_FLOOR_US 16'h0C1C
`define CONST_ARITH_US 16'h0708
`define CONST_CC_US 16'h21FC
`define FETCH_US 16'h0C1C

// ==========================================================
// Sequencing step codes
// ==========================================================
`define STEP_SETTLE 2'h0
`define STEP_LOAD 2'h1
`define STEP_WAIT 2'h2

`endif

//--- branch_timing_pkg.sv
// Types shared by the branch condition and step timing block
package branch_timing_pkg;

	// ==========================================================
	// Enumerations
	// ==========================================================
	typedef enum logic [2:0] {
		OP_ADD, OP_SUB, OP_ADD_CHECK, OP_SUB_CHECK,
		OP_MUL, OP_DIV, OP_CHANNEL_CLEAR, OP_OTHER
	} op_e;

	typedef enum logic [1:0] {OPD_NUMERIC, OPD_ALPHA, OPD_ALPHA_SIGN} opd_e;

	typedef enum logic [3:0] {
		LOC_NONE, LOC_REG, LOC_BUF_WORD, LOC_DRUM_WORD, LOC_BUF_FIELD_B,
		LOC_DRUM_FIELD, LOC_BTB_FILL_GSB, LOC_BTB_FILL_DRUM,
		LOC_BTB_TO_DRUM, LOC_BTB_WHOLE
	} loc_e;

	typedef enum logic [1:0] {BR_ZERO, BR_PLUS, BR_MINUS} branch_e;

	typedef enum logic [2:0] {
		PH_IDLE, PH_V1, PH_V2, PH_PROC, PH_RES, PH_CONST, PH_FETCH
	} phase_e;

	// ==========================================================
	// Carriers
	// ==========================================================
	typedef struct packed {
		op_e op;
		opd_e opClass;
		logic isWord;
		logic resultMinus;
		logic resultZero;
		loc_e v1Loc;
		loc_e v2Loc;
		loc_e rLoc;
		logic [2:0] shiftEn;
		logic [6:0] shiftU;
		logic [6:0] shiftV;
		logic [6:0] shiftW;
		logic [6:0] fieldX;
		logic [6:0] fieldZ;
		logic [15:0] procUs;
		logic [15:0] constUs;
	} cmd_s;

	typedef struct packed {
		logic busy;
		logic done;
		logic fetchActive;
		phase_e phase;
		branch_e branch;
	} status_s;

	typedef struct packed {
		logic [15:0] usLeft;
		logic [6:0] pre;
		logic run;
		logic expired;
	} timer_s;

	typedef struct packed {
		logic [15:0] timeUs;
	} calc_s;

	typedef struct packed {
		phase_e phase;
		logic [1:0] step;
		cmd_s cmd;
		logic [15:0] procUs;
		branch_e branch;
		logic busy;
		logic done;
		logic fetchActive;
	} top_s;

endpackage : branch_timing_pkg

//--- phase_timer.sv
// Microsecond phase timer with a cycle prescaler
`include "branch_timing_defs.svh"

module phase_timer #(
	parameter logic [6:0] CYCLES_PER_US = `CLK_MHZ
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic load,
	input wire logic [15:0] loadUs,
	output logic expired
);

	branch_timing_pkg::timer_s st_ff;
	branch_timing_pkg::timer_s nxt_st;

	// ==========================================================
	// Next state: load, prescale, count down, expire
	// ==========================================================
	always_comb begin
		nxt_st = st_ff;
		nxt_st.expired = 1'b0;
		if (load) begin
			nxt_st.usLeft = loadUs;
			nxt_st.pre = 7'h00;
			nxt_st.run = 1'b1;
		end else if (st_ff.run) begin
			if (st_ff.usLeft == 16'h0000) begin
				nxt_st.run = 1'b0;
				nxt_st.expired = 1'b1;
			end else if (st_ff.pre == CYCLES_PER_US - 7'h01) begin
				nxt_st.pre = 7'h00;
				nxt_st.usLeft = st_ff.usLeft - 16'h0001;
			end else begin
				nxt_st.pre = st_ff.pre + 7'h01;
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign expired = st_ff.expired;

endmodule : phase_timer

//--- mem_time_calc.sv
// Registered reference time of one location, shift time included
`include "branch_timing_defs.svh"

module mem_time_calc (
	input wire logic ref_clk,
	input wire logic reset_n,
	input branch_timing_pkg::loc_e loc,
	input wire logic [6:0] fieldX,
	input wire logic [6:0] fieldZ,
	input wire logic shiftEn,
	input wire logic [6:0] shiftN,
	output logic [15:0] timeUs
);

	branch_timing_pkg::calc_s st_ff;
	branch_timing_pkg::calc_s nxt_st;
	logic [15:0] posUs;
	logic [15:0] charUs;
	logic [15:0] shiftUs;

	// Field position, field length and shift terms
	assign posUs = {9'h000, fieldX} * `FIELD_POS_US;
	assign charUs = {9'h000, fieldZ} * `CHAR_US;
	assign shiftUs = shiftEn ? ({9'h000, shiftN} + 16'h0001) * `SHIFT_US : 16'h0000;

	// ==========================================================
	// Location time table
	// ==========================================================
	always_comb begin
		nxt_st.timeUs = 16'h0000;
		case (loc)
			branch_timing_pkg::LOC_REG: nxt_st.timeUs = `REF_REG_US;
			branch_timing_pkg::LOC_BUF_WORD: nxt_st.timeUs = `LOAD_BUF_US;
			branch_timing_pkg::LOC_DRUM_WORD: nxt_st.timeUs = `LOAD_DRUM_US;
			branch_timing_pkg::LOC_BUF_FIELD_B: nxt_st.timeUs = posUs + `LOAD_BUF_US;
			branch_timing_pkg::LOC_DRUM_FIELD: begin
				nxt_st.timeUs = (fieldZ > `FIELD_SHORT_CHARS) ?
					charUs + `STORE_DRUM_US : `STORE_DRUM_US;
			end
			branch_timing_pkg::LOC_BTB_FILL_GSB: nxt_st.timeUs = `BTB_FILL_GSB_US;
			branch_timing_pkg::LOC_BTB_FILL_DRUM: nxt_st.timeUs = `BTB_FILL_DRUM_US;
			branch_timing_pkg::LOC_BTB_TO_DRUM: nxt_st.timeUs = `BTB_TO_DRUM_US;
			branch_timing_pkg::LOC_BTB_WHOLE: nxt_st.timeUs = `BTB_WHOLE_US;
			default: nxt_st.timeUs = 16'h0000;
		endcase
		if (loc != branch_timing_pkg::LOC_NONE) begin
			nxt_st.timeUs = nxt_st.timeUs + shiftUs;
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign timeUs = st_ff.timeUs;

endmodule : mem_time_calc

//--- branch_condition_and_step_timing.sv
// Branch condition store and instruction execution timing sequencer
//
// Operation
// - Alpha-sign add or subtract leaves the branch condition at zero.
// - Multiply sets plus, minus, or zero for a zero product.
// - Divide sets plus or minus from quotient sign, never zero.
// - Next instruction is located during the current word's process phase.
// - Instruction word process phase lasts at least 3.1 ms.
// - Instruction words add a per-operation constant: 1.8 ms, 8.7 for channel clear, the commanded time for other.
// - Each shifted operand or result adds 0.042 times (n plus one) ms.
// - Arithmetic and special register references take 0.9 ms.
// - Loads take 0.9 buffer, 3.1 drum, B field 0.021x plus 0.9.
// - Stores take 0.9 buffer, 3.1 drum, long drum field 0.042z plus 3.1.
// - Full block fill takes 5.4 ms from buffer, 7.7 from drum.
// - Block buffer out: 0.9 buffer word, 3.2 drum word, 5.1 whole block.
// - Add/subtract process: 1.2 numeric, 2.5 with check, 0.7 alpha.
// - Channel clear never overlaps the next instruction fetch.
// - Alpha add or subtract always sets plus or minus.
`include "branch_timing_defs.svh"

module branch_condition_and_step_timing #(
	parameter logic [6:0] CYCLES_PER_US = `CLK_MHZ
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic cmdStart,
	input branch_timing_pkg::cmd_s cmd,
	output branch_timing_pkg::status_s status
);

	branch_timing_pkg::top_s st_ff;
	branch_timing_pkg::top_s nxt_st;
	branch_timing_pkg::loc_e calcLoc;
	logic calcShiftEn;
	logic [6:0] calcShiftN;
	logic [15:0] calcUs;
	logic timerLoad;
	logic [15:0] timerUs;
	logic timerExpired;
	logic [15:0] rawProcUs;
	logic [15:0] constUs;
	logic isAddSub;
	logic isCheck;
	logic isAlpha;

	// ==========================================================
	// Operation decode on the incoming command
	// ==========================================================
	assign isAddSub = (cmd.op == branch_timing_pkg::OP_ADD) ||
		(cmd.op == branch_timing_pkg::OP_SUB) ||
		(cmd.op == branch_timing_pkg::OP_ADD_CHECK) ||
		(cmd.op == branch_timing_pkg::OP_SUB_CHECK);
	assign isCheck = (cmd.op == branch_timing_pkg::OP_ADD_CHECK) ||
		(cmd.op == branch_timing_pkg::OP_SUB_CHECK);
	assign isAlpha = (cmd.opClass != branch_timing_pkg::OPD_NUMERIC);

	// Raw process time taken at command start
	always_comb begin
		if (isAddSub) begin
			if (isAlpha) begin
				rawProcUs = `ADD_ALPHA_US;
			end else if (isCheck) begin
				rawProcUs = `ADD_CHECK_US;
			end else begin
				rawProcUs = `ADD_NUM_US;
			end
		end else begin
			rawProcUs = cmd.procUs;
		end
	end

	// Per-operation instruction word constant
	always_comb begin
		case (st_ff.cmd.op)
			branch_timing_pkg::OP_CHANNEL_CLEAR: constUs = `CONST_CC_US;
			branch_timing_pkg::OP_OTHER: constUs = st_ff.cmd.constUs;
			default: constUs = `CONST_ARITH_US;
		endcase
	end

	// ==========================================================
	// Location time calculator input select
	// ==========================================================
	always_comb begin
		calcLoc = branch_timing_pkg::LOC_NONE;
		calcShiftEn = 1'b0;
		calcShiftN = 7'h00;
		case (st_ff.phase)
			branch_timing_pkg::PH_V1: begin
				calcLoc = st_ff.cmd.v1Loc;
				calcShiftEn = st_ff.cmd.shiftEn[0];
				calcShiftN = st_ff.cmd.shiftU;
			end
			branch_timing_pkg::PH_V2: begin
				calcLoc = st_ff.cmd.v2Loc;
				calcShiftEn = st_ff.cmd.shiftEn[1];
				calcShiftN = st_ff.cmd.shiftV;
			end
			branch_timing_pkg::PH_RES: begin
				calcLoc = st_ff.cmd.rLoc;
				calcShiftEn = st_ff.cmd.shiftEn[2];
				calcShiftN = st_ff.cmd.shiftW;
			end
			default: calcLoc = branch_timing_pkg::LOC_NONE;
		endcase
	end

	mem_time_calc u_calc (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.loc(calcLoc),
		.fieldX(st_ff.cmd.fieldX),
		.fieldZ(st_ff.cmd.fieldZ),
		.shiftEn(calcShiftEn),
		.shiftN(calcShiftN),
		.timeUs(calcUs)
	);

	// Timer load select per phase
	always_comb begin
		case (st_ff.phase)
			branch_timing_pkg::PH_PROC: timerUs = st_ff.procUs;
			branch_timing_pkg::PH_CONST: timerUs = constUs;
			branch_timing_pkg::PH_FETCH: timerUs = `FETCH_US;
			default: timerUs = calcUs;
		endcase
	end

	assign timerLoad = (st_ff.phase != branch_timing_pkg::PH_IDLE) &&
		(st_ff.step == `STEP_LOAD);

	phase_timer #(
		.CYCLES_PER_US(CYCLES_PER_US)
	) u_timer (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.load(timerLoad),
		.loadUs(timerUs),
		.expired(timerExpired)
	);

	// ==========================================================
	// Sequencer and branch condition store
	// ==========================================================
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		case (st_ff.phase)
			branch_timing_pkg::PH_IDLE: begin
				if (cmdStart) begin
					nxt_st.cmd = cmd;
					nxt_st.busy = 1'b1;
					nxt_st.phase = branch_timing_pkg::PH_V1;
					nxt_st.step = `STEP_SETTLE;
					if (cmd.isWord && (rawProcUs < `PROC_FLOOR_US)) begin
						nxt_st.procUs = `PROC_FLOOR_US;
					end else begin
						nxt_st.procUs = rawProcUs;
					end
				end
			end
			default: begin
				if (st_ff.step == `STEP_SETTLE) begin
					nxt_st.step = `STEP_LOAD;
				end else if (st_ff.step == `STEP_LOAD) begin
					nxt_st.step = `STEP_WAIT;
				end else if (timerExpired) begin
					nxt_st.step = `STEP_SETTLE;
					case (st_ff.phase)
						branch_timing_pkg::PH_V1: begin
							nxt_st.phase = branch_timing_pkg::PH_V2;
						end
						branch_timing_pkg::PH_V2: begin
							nxt_st.phase = branch_timing_pkg::PH_PROC;
						end
						branch_timing_pkg::PH_PROC: begin
							nxt_st.phase = branch_timing_pkg::PH_RES;
							case (st_ff.cmd.op)
								branch_timing_pkg::OP_MUL: begin
									if (st_ff.cmd.resultZero) begin
										nxt_st.branch = branch_timing_pkg::BR_ZERO;
									end else if (st_ff.cmd.resultMinus) begin
										nxt_st.branch = branch_timing_pkg::BR_MINUS;
									end else begin
										nxt_st.branch = branch_timing_pkg::BR_PLUS;
									end
								end
								branch_timing_pkg::OP_DIV: begin
									nxt_st.branch = st_ff.cmd.resultMinus ?
										branch_timing_pkg::BR_MINUS : branch_timing_pkg::BR_PLUS;
								end
								branch_timing_pkg::OP_CHANNEL_CLEAR, branch_timing_pkg::OP_OTHER: begin
									nxt_st.branch = st_ff.branch;
								end
								default: begin
									if (st_ff.cmd.opClass == branch_timing_pkg::OPD_ALPHA_SIGN) begin
										nxt_st.branch = branch_timing_pkg::BR_ZERO;
									end else if (st_ff.cmd.opClass == branch_timing_pkg::OPD_ALPHA) begin
										nxt_st.branch = st_ff.cmd.resultMinus ?
											branch_timing_pkg::BR_MINUS : branch_timing_pkg::BR_PLUS;
									end else if (st_ff.cmd.resultZero) begin
										nxt_st.branch = branch_timing_pkg::BR_ZERO;
									end else begin
										nxt_st.branch = st_ff.cmd.resultMinus ?
											branch_timing_pkg::BR_MINUS : branch_timing_pkg::BR_PLUS;
									end
								end
							endcase
						end
						branch_timing_pkg::PH_RES: begin
							if (st_ff.cmd.isWord) begin
								nxt_st.phase = branch_timing_pkg::PH_CONST;
							end else begin
								nxt_st.phase = branch_timing_pkg::PH_IDLE;
								nxt_st.busy = 1'b0;
								nxt_st.done = 1'b1;
							end
						end
						branch_timing_pkg::PH_CONST: begin
							if (st_ff.cmd.op == branch_timing_pkg::OP_CHANNEL_CLEAR) begin
								nxt_st.phase = branch_timing_pkg::PH_FETCH;
							end else begin
								nxt_st.phase = branch_timing_pkg::PH_IDLE;
								nxt_st.busy = 1'b0;
								nxt_st.done = 1'b1;
							end
						end
						default: begin
							nxt_st.phase = branch_timing_pkg::PH_IDLE;
							nxt_st.busy = 1'b0;
							nxt_st.done = 1'b1;
						end
					endcase
				end
			end
		endcase
		nxt_st.fetchActive = nxt_st.cmd.isWord &&
			(((nxt_st.phase == branch_timing_pkg::PH_PROC) &&
			(nxt_st.cmd.op != branch_timing_pkg::OP_CHANNEL_CLEAR)) ||
			(nxt_st.phase == branch_timing_pkg::PH_FETCH));
	end

	// State register
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// Outputs straight from the state register
	// ==========================================================
	assign status.busy = st_ff.busy;
	assign status.done = st_ff.done;
	assign status.fetchActive = st_ff.fetchActive;
	assign status.phase = st_ff.phase;
	assign status.branch = st_ff.branch;

endmodule : branch_condition_and_step_timing

//--- branch_condition_and_step_timing_sva.sv
// Port-level checker for the branch condition and step timing block
module branch_condition_and_step_timing_sva #(
	parameter logic [6:0] CYCLES_PER_US = 7'h64
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic cmdStart,
	input branch_timing_pkg::cmd_s cmd,
	input branch_timing_pkg::status_s status
);
	// ==========================================================
	// Helper state
	// ==========================================================
	branch_timing_pkg::cmd_s cmdLat_ff;
	branch_timing_pkg::branch_e brLat_ff;
	logic addFam;
	logic m;

	// Capture the command and branch at an accepted start
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmdLat_ff <= '0;
			brLat_ff <= branch_timing_pkg::BR_ZERO;
		end else if (cmdStart && status.phase == branch_timing_pkg::PH_IDLE && !status.busy) begin
			cmdLat_ff <= cmd;
			brLat_ff <= status.branch;
		end
	end

	// Add and subtract family, result sign
	assign addFam = cmdLat_ff.op inside {branch_timing_pkg::OP_ADD, branch_timing_pkg::OP_SUB,
		branch_timing_pkg::OP_ADD_CHECK, branch_timing_pkg::OP_SUB_CHECK};
	assign m = cmdLat_ff.resultMinus;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// ==========================================================
	// Branch condition store
	// ==========================================================
	property p_alpha_sign;
		status.done && addFam && cmdLat_ff.opClass == branch_timing_pkg::OPD_ALPHA_SIGN
			|-> status.branch == branch_timing_pkg::BR_ZERO;
	endproperty
	a_alpha_sign: assert property (p_alpha_sign)
		else $error("alpha-sign result did not leave zero");
	property p_mul;
		status.done && cmdLat_ff.op == branch_timing_pkg::OP_MUL |-> status.branch ==
			(cmdLat_ff.resultZero ? branch_timing_pkg::BR_ZERO :
			m ? branch_timing_pkg::BR_MINUS : branch_timing_pkg::BR_PLUS);
	endproperty
	a_mul: assert property (p_mul)
		else $error("multiply branch setting wrong");
	property p_div;
		status.done && cmdLat_ff.op == branch_timing_pkg::OP_DIV |-> status.branch ==
			(m ? branch_timing_pkg::BR_MINUS : branch_timing_pkg::BR_PLUS);
	endproperty
	a_div: assert property (p_div)
		else $error("divide branch setting wrong");
	property p_alpha;
		status.done && addFam && cmdLat_ff.opClass == branch_timing_pkg::OPD_ALPHA
			|-> status.branch == (m ? branch_timing_pkg::BR_MINUS : branch_timing_pkg::BR_PLUS);
	endproperty
	a_alpha: assert property (p_alpha)
		else $error("alpha result branch setting wrong");
	property p_keep;
		status.done && cmdLat_ff.op inside {branch_timing_pkg::OP_CHANNEL_CLEAR,
			branch_timing_pkg::OP_OTHER} |-> status.branch == brLat_ff;
	endproperty
	a_keep: assert property (p_keep)
		else $error("branch changed by a non-arithmetic step");
	property p_three;
		$changed(status.branch) |-> status.branch != 2'h3 && status.busy;
	endproperty
	a_three: assert property (p_three)
		else $error("branch left the three states or changed idle");

	// ==========================================================
	// Next-instruction locate
	// ==========================================================
	property p_fetch;
		status.fetchActive |-> cmdLat_ff.isWord && (status.phase inside
			{branch_timing_pkg::PH_PROC, branch_timing_pkg::PH_FETCH} ||
			$past(status.phase) inside {branch_timing_pkg::PH_PROC, branch_timing_pkg::PH_FETCH});
	endproperty
	a_fetch: assert property (p_fetch)
		else $error("locate outside process or fetch");
	property p_cc_fetch;
		status.fetchActive && cmdLat_ff.op == branch_timing_pkg::OP_CHANNEL_CLEAR
			|-> status.phase == branch_timing_pkg::PH_FETCH ||
			$past(status.phase) == branch_timing_pkg::PH_FETCH;
	endproperty
	a_cc_fetch: assert property (p_cc_fetch)
		else $error("channel clear overlapped the fetch");
endmodule : branch_condition_and_step_timing_sva

//--- tb_branch_condition_and_step_timing.sv
// Self-checking testbench for the branch condition and step timing block
module tb_branch_condition_and_step_timing;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [6:0] P = 7'h01;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic cmdStart = 1'b0;
	branch_timing_pkg::cmd_s cmd = '0;
	branch_timing_pkg::status_s status;
	int miscompares = 0;
	int num_checks = 0;
	int dur [8];
	logic fetchProc = 1'b0;
	logic fetchFetch = 1'b0;

	branch_condition_and_step_timing #(.CYCLES_PER_US(P)) branch_condition_and_step_timing_inst (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.cmdStart(cmdStart),
		.cmd(cmd),
		.status(status)
	);

	// Clock at 100 MHz
	initial forever #5 ref_clk = ~ref_clk;

	// Per-phase cycle counts and locate observations
	always @(posedge ref_clk) begin
		if (status.busy === 1'b1) begin
			dur[int'(status.phase)] += 1;
			if (status.fetchActive === 1'b1 && status.phase == branch_timing_pkg::PH_PROC) fetchProc = 1'b1;
			if (status.fetchActive === 1'b1 && status.phase == branch_timing_pkg::PH_FETCH) fetchFetch = 1'b1;
		end
	end

	// ==========================================================
	// Shared tasks
	// ==========================================================
	task results();
		$display("checks=%0d miscompares=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Phase length is the time plus a few sequencing cycles
	task near(input branch_timing_pkg::phase_e ph, input int us);
		int d;
		d = dur[int'(ph)];
		chk((d >= us * int'(P) && d <= us * int'(P) + 8) ? us : d, us);
	endtask : near

	task run(input branch_timing_pkg::cmd_s c);
		int n;
		@(posedge ref_clk);
		#1;
		cmdStart = 1'b1;
		cmd = c;
		dur = '{default: 0};
		fetchProc = 1'b0;
		fetchFetch = 1'b0;
		@(posedge ref_clk);
		#1;
		cmdStart = 1'b0;
		n = 0;
		while (status.done !== 1'b1 && n < 40000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk(status.done, 1'b1);
	endtask : run

	task brc(input branch_timing_pkg::op_e op, input branch_timing_pkg::opd_e cl, input logic mi,
		input logic z, input branch_timing_pkg::branch_e e);
		branch_timing_pkg::cmd_s c;
		c = '0;
		c.op = op;
		c.opClass = cl;
		c.resultMinus = mi;
		c.resultZero = z;
		run(c);
		chk(status.branch, e);
	endtask : brc

	// ==========================================================
	// Scenarios
	// ==========================================================
	task t_mul();
		brc(branch_timing_pkg::OP_MUL, branch_timing_pkg::OPD_NUMERIC, 1'b0, 1'b0, branch_timing_pkg::BR_PLUS);
		brc(branch_timing_pkg::OP_MUL, branch_timing_pkg::OPD_NUMERIC, 1'b1, 1'b0, branch_timing_pkg::BR_MINUS);
		brc(branch_timing_pkg::OP_MUL, branch_timing_pkg::OPD_NUMERIC, 1'b1, 1'b1, branch_timing_pkg::BR_ZERO);
	endtask : t_mul

	task t_div();
		brc(branch_timing_pkg::OP_DIV, branch_timing_pkg::OPD_NUMERIC, 1'b0, 1'b1, branch_timing_pkg::BR_PLUS);
		brc(branch_timing_pkg::OP_DIV, branch_timing_pkg::OPD_NUMERIC, 1'b1, 1'b1, branch_timing_pkg::BR_MINUS);
	endtask : t_div

	task t_alpha();
		brc(branch_timing_pkg::OP_SUB, branch_timing_pkg::OPD_ALPHA, 1'b1, 1'b1, branch_timing_pkg::BR_MINUS);
		brc(branch_timing_pkg::OP_ADD, branch_timing_pkg::OPD_ALPHA, 1'b0, 1'b1, branch_timing_pkg::BR_PLUS);
	endtask : t_alpha

	task t_alpha_sign();
		brc(branch_timing_pkg::OP_ADD_CHECK, branch_timing_pkg::OPD_ALPHA_SIGN, 1'b0, 1'b0, branch_timing_pkg::BR_ZERO);
		brc(branch_timing_pkg::OP_MUL, branch_timing_pkg::OPD_NUMERIC, 1'b1, 1'b0, branch_timing_pkg::BR_MINUS);
		brc(branch_timing_pkg::OP_SUB, branch_timing_pkg::OPD_ALPHA_SIGN, 1'b1, 1'b0, branch_timing_pkg::BR_ZERO);
	endtask : t_alpha_sign

	task t_word_add();
		branch_timing_pkg::cmd_s c;
		c = '0;
		c.isWord = 1'b1;
		c.v1Loc = branch_timing_pkg::LOC_REG;
		c.v2Loc = branch_timing_pkg::LOC_DRUM_WORD;
		c.rLoc = branch_timing_pkg::LOC_BUF_WORD;
		run(c);
		near(branch_timing_pkg::PH_V1, 900);
		near(branch_timing_pkg::PH_V2, 3100);
		near(branch_timing_pkg::PH_PROC, 3100);
		near(branch_timing_pkg::PH_RES, 900);
		near(branch_timing_pkg::PH_CONST, 1800);
		chk(fetchProc, 1'b1);
	endtask : t_word_add

	task t_step_fields();
		branch_timing_pkg::cmd_s c;
		c = '0;
		c.op = branch_timing_pkg::OP_SUB_CHECK;
		c.v1Loc = branch_timing_pkg::LOC_BUF_FIELD_B;
		c.fieldX = 7'h0A;
		c.rLoc = branch_timing_pkg::LOC_DRUM_FIELD;
		c.fieldZ = 7'h14;
		c.shiftEn = 3'h5;
		c.shiftU = 7'h03;
		run(c);
		near(branch_timing_pkg::PH_V1, 1278);
		near(branch_timing_pkg::PH_PROC, 2500);
		near(branch_timing_pkg::PH_RES, 3982);
		chk(dur[int'(branch_timing_pkg::PH_CONST)], 32'h0);
	endtask : t_step_fields

	task t_alpha_time();
		branch_timing_pkg::cmd_s c;
		c = '0;
		c.opClass = branch_timing_pkg::OPD_ALPHA;
		c.v2Loc = branch_timing_pkg::LOC_DRUM_FIELD;
		c.fieldZ = 7'h0C;
		c.rLoc = branch_timing_pkg::LOC_BTB_WHOLE;
		run(c);
		near(branch_timing_pkg::PH_V2, 3100);
		near(branch_timing_pkg::PH_PROC, 700);
		near(branch_timing_pkg::PH_RES, 5100);
	endtask : t_alpha_time

	task t_btb();
		branch_timing_pkg::cmd_s c;
		branch_timing_pkg::branch_e b;
		b = status.branch;
		c = '0;
		c.op = branch_timing_pkg::OP_OTHER;
		c.v1Loc = branch_timing_pkg::LOC_BTB_FILL_GSB;
		c.v2Loc = branch_timing_pkg::LOC_BTB_FILL_DRUM;
		c.rLoc = branch_timing_pkg::LOC_BTB_TO_DRUM;
		run(c);
		near(branch_timing_pkg::PH_V1, 5400);
		near(branch_timing_pkg::PH_V2, 7700);
		near(branch_timing_pkg::PH_RES, 3200);
		chk(status.branch, b);
	endtask : t_btb

	task t_cc();
		branch_timing_pkg::cmd_s c;
		branch_timing_pkg::branch_e b;
		b = status.branch;
		c = '0;
		c.op = branch_timing_pkg::OP_CHANNEL_CLEAR;
		c.isWord = 1'b1;
		run(c);
		near(branch_timing_pkg::PH_PROC, 3100);
		near(branch_timing_pkg::PH_CONST, 8700);
		chk(fetchProc, 1'b0);
		chk(fetchFetch, 1'b1);
		chk(status.branch, b);
	endtask : t_cc

	// Main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		chk(status.branch, branch_timing_pkg::BR_ZERO);
		t_mul();
		t_div();
		t_alpha();
		t_alpha_sign();
		t_word_add();
		t_step_fields();
		t_alpha_time();
		t_btb();
		t_cc();
		results();
	end

	// Watchdog against a hang
	initial begin
		repeat (90000) @(posedge ref_clk);
		miscompares++;
		results();
	end
endmodule : tb_branch_condition_and_step_timing

bind branch_condition_and_step_timing branch_condition_and_step_timing_sva #(
	.CYCLES_PER_US(CYCLES_PER_US)
) branch_condition_and_step_timing_sva_inst (
	.ref_clk(ref_clk),
	.reset_n(reset_n),
	.cmdStart(cmdStart),
	.cmd(cmd),
	.status(status)
);
